// ==== rtl/ipfe_pkg.sv ====
// Constants for the interrupt pin front end.
// Assumes a single core clock domain.
package ipfe_pkg;
   localparam int unsigned IPFE_NUM_EXT     = 4;
   localparam int unsigned IPFE_ID_W        = 4;
   localparam logic [3:0]  IPFE_ID_NMI      = 4'h1;
   localparam logic [3:0]  IPFE_ID_EXT_BASE = 4'h4;
   localparam logic [4:0]  IPFE_SEL_EXT4    = 5'h04;
   localparam logic [4:0]  IPFE_SEL_EXT7    = 5'h07;
   localparam logic [3:0]  IPFE_POL_RESET   = 4'h0;
   localparam logic [31:0] IPFE_REG_POLARITY = 32'h0000_0000;
   localparam logic [31:0] IPFE_REG_PENDING  = 32'h0000_0004;
   localparam logic [31:0] IPFE_REG_SERVICE  = 32'h0000_0008;
   localparam int unsigned IPFE_SVC_ACK_BIT = 4;
   localparam logic [1:0]  IPFE_WARM_DONE   = 2'h3;
   localparam logic [31:0] IPFE_UNMAPPED    = 32'hdead_beef;
endpackage

// ==== rtl/ipfe_top.sv ====
// Interrupt pin front end: edge detection, pending latches, acknowledge and id output.
// Assumes asynchronous pins, Avalon-MM register access on the core clock.
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module ipfe_top
   import ipfe_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   input  wire logic        enable_in,
   input  wire logic        nmi_in,
   input  wire logic        external_request_line_4_in,
   input  wire logic        external_request_line_5_in,
   input  wire logic        external_request_line_6_in,
   input  wire logic        external_request_line_7_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic      [3:0]  pending_out,
   output logic             nmi_pending_out,
   output logic             service_acknowledge_out,
   output logic             serviced_id_bit_3_out,
   output logic             serviced_id_bit_2_out,
   output logic             serviced_id_bit_1_out,
   output logic             serviced_id_bit_0_out
);
   logic [4:0]  raw;
   logic [4:0]  sync1;
   logic [4:0]  sync2;
   logic [4:0]  prev;
   logic [4:0]  next_prev;
   logic [4:0]  edge_hit;
   logic [3:0]  line_hit;
   logic [1:0]  warm;
   logic [1:0]  next_warm;
   logic [3:0]  edge_polarity_bits;
   logic [3:0]  next_polarity;
   logic [4:0]  pend;
   logic [4:0]  next_pend;
   logic [4:0]  clr;
   logic        ack;
   logic        next_ack;
   logic [3:0]  id;
   logic [3:0]  next_id;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic        wreq;
   logic        next_wreq;
   logic [4:0]  selector [IPFE_NUM_EXT];
   logic [31:0] byte_addr;

   assign raw = {external_request_line_7_in, external_request_line_6_in,
                 external_request_line_5_in, external_request_line_4_in, nmi_in};
   assign byte_addr = {28'h0000000, avs_address_in};

   // Default selector codes for numbers four to seven
   genvar g;
   generate
      for (g = 0; g < IPFE_NUM_EXT; g++)
      begin : g_sel
         assign selector[g] = IPFE_SEL_EXT4 + 5'(g);
      end
   endgenerate

   // Two-stage synchroniser
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
      end
      else if (enable_in)
      begin
         sync1 <= raw;
         sync2 <= sync1;
      end
   end

   // Edge detection and pending latches
   always_comb
   begin
      next_prev = sync2;
      edge_hit[0] = sync2[0] & ~prev[0];
      for (int i = 0; i < IPFE_NUM_EXT; i++)
      begin
         line_hit[i] = edge_polarity_bits[i] ? (~sync2[i+1] & prev[i+1])
                                             : (sync2[i+1] & ~prev[i+1]);
      end
      for (int i = 0; i < IPFE_NUM_EXT; i++)
      begin
         edge_hit[i+1] = line_hit[selector[i][1:0]];
      end
      // Pins held active through reset are a level, not an edge; edges in the first cycles are lost
      if (warm != IPFE_WARM_DONE)
      begin
         edge_hit = 5'h00;
      end
      next_warm = (warm == IPFE_WARM_DONE) ? warm : warm + 2'h1;
      next_pend = (pend & ~clr) | edge_hit;
   end

   // Service: highest priority pending entry, one per cycle
   always_comb
   begin
      clr = 5'h00;
      next_ack = 1'b0;
      next_id = id;
      if (wreq)
      begin
         if (pend[0])
         begin
            clr[0] = 1'b1;
            next_ack = 1'b1;
            next_id = IPFE_ID_NMI;
         end
         else
         begin
            for (int i = IPFE_NUM_EXT - 1; i >= 0; i--)
            begin
               if (pend[i+1])
               begin
                  clr = 5'h00;
                  clr[i+1] = 1'b1;
                  next_ack = 1'b1;
                  next_id = IPFE_ID_EXT_BASE + 4'(i);
               end
            end
         end
      end
   end

   // Register bus
   always_comb
   begin
      next_wreq = 1'b0;
      next_polarity = edge_polarity_bits;
      next_rdata = rdata;
      if ((avs_read_in || avs_write_in) && avs_waitrequest_out)
      begin
         next_wreq = avs_write_in && (byte_addr == IPFE_REG_SERVICE) && avs_writedata_in[IPFE_SVC_ACK_BIT];
         if (avs_write_in && byte_addr == IPFE_REG_POLARITY)
         begin
            next_polarity = avs_writedata_in[3:0];
         end
         if (byte_addr == IPFE_REG_POLARITY)
         begin
            next_rdata = {28'h0000000, edge_polarity_bits};
         end
         else if (byte_addr == IPFE_REG_PENDING)
         begin
            next_rdata = {27'h0, pend};
         end
         else if (byte_addr == IPFE_REG_SERVICE)
         begin
            next_rdata = {27'h0, ack, id};
         end
         else
         begin
            next_rdata = IPFE_UNMAPPED;
         end
      end
   end

   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         prev <= 5'h00;
         pend <= 5'h00;
         ack <= 1'b0;
         id <= 4'h0;
         edge_polarity_bits <= IPFE_POL_RESET;
         rdata <= 32'h00000000;
         wreq <= 1'b0;
         warm <= 2'h0;
         avs_waitrequest_out <= 1'b1;
      end
      else if (enable_in)
      begin
         prev <= next_prev;
         pend <= next_pend;
         ack <= next_ack;
         id <= next_id;
         edge_polarity_bits <= next_polarity;
         rdata <= next_rdata;
         wreq <= next_wreq;
         warm <= next_warm;
         avs_waitrequest_out <= ~((avs_read_in || avs_write_in) && avs_waitrequest_out);
      end
   end

   assign avs_readdata_out = rdata;
   assign pending_out = pend[4:1];
   assign nmi_pending_out = pend[0];
   assign service_acknowledge_out = ack;
   assign serviced_id_bit_3_out = id[3];
   assign serviced_id_bit_2_out = id[2];
   assign serviced_id_bit_1_out = id[1];
   assign serviced_id_bit_0_out = id[0];

   property p_nmi_edge;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && warm == IPFE_WARM_DONE && sync2[0] && !prev[0]) |=> pend[0];
   endproperty
   a_nmi_edge: assert property (p_nmi_edge) else $error("Nmi edge not latched");

   property p_nmi_level;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && prev[0] && !pend[0]) |=> !pend[0] || $past(sync2[0] && !prev[0]);
   endproperty
   a_nmi_level: assert property (p_nmi_level) else $error("Nmi level triggered");

   property p_ext_edge;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && warm == IPFE_WARM_DONE && !edge_polarity_bits[0] && sync2[1] && !prev[1]) |=> pend[1];
   endproperty
   a_ext_edge: assert property (p_ext_edge) else $error("Rising edge lost");

   property p_ext_fall;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && warm == IPFE_WARM_DONE && edge_polarity_bits[0] && !sync2[1] && prev[1]) |=> pend[1];
   endproperty
   a_ext_fall: assert property (p_ext_fall) else $error("Falling edge lost");

   property p_ack_pulse;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && ack) |=> !ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("Ack longer than one cycle");

   property p_ack_cause;
      @(posedge clock_in) disable iff (reset_in)
      $rose(ack) |-> $past(wreq && pend != 5'h00);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("Ack without service");

   property p_id_range;
      @(posedge clock_in) disable iff (reset_in)
      ack |-> (id == IPFE_ID_NMI) || (id >= 4'h4 && id <= 4'h7);
   endproperty
   a_id_range: assert property (p_id_range) else $error("Bad serviced id");

   property p_nmi_first;
      @(posedge clock_in) disable iff (reset_in)
      (enable_in && wreq && pend[0]) |=> (ack && id == 4'h1);
   endproperty
   a_nmi_first: assert property (p_nmi_first) else $error("Priority order broken");

   property p_sel_map;
      @(posedge clock_in) disable iff (reset_in)
      selector[0] == 5'h04 && selector[3] == IPFE_SEL_EXT7;
   endproperty
   a_sel_map: assert property (p_sel_map) else $error("Selector defaults wrong");
endmodule
`default_nettype wire

// ==== testbench/interrupt_pin_front_end_test.sv ====
// Self-checking bench for the interrupt pin front end.
// Assumes ipfe_top and the source model ipfe_src.
`timescale 1ns/1ns
`default_nettype none
module interrupt_pin_front_end_test;
   import ipfe_pkg::*;
   typedef struct {logic [3:0] pol; logic [2:0] sel; logic lvl; logic [4:0] pend; logic [3:0] id;} ipfe_row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        en  = 1'b1;
   logic        set = 1'b0;
   logic [2:0]  sel = 3'h0;
   logic        lvl = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd  = 1'b0;
   logic        wr  = 1'b0;
   logic [31:0] wd  = 32'h0;
   logic [31:0] rdata;
   logic [31:0] q;
   logic        wait_q;
   logic        nmip;
   logic        ack;
   logic [3:0]  pend;
   wire  [3:0]  id;
   logic [3:0]  last_id;
   logic [4:0]  pins;
   logic [7:0]  acks;
   logic [7:0]  nacks = 8'h00;
   int          fails = 0;
   int          checked = 0;
   ipfe_row_t   rows [9] = '{'{4'h0, 3'h0, 1'b1, 5'h01, 4'h1}, '{4'h0, 3'h0, 1'b0, 5'h00, 4'h0},
      '{4'h0, 3'h1, 1'b1, 5'h02, 4'h4}, '{4'h0, 3'h2, 1'b1, 5'h04, 4'h5}, '{4'h2, 3'h2, 1'b0, 5'h04, 4'h5},
      '{4'h2, 3'h3, 1'b1, 5'h08, 4'h6}, '{4'h2, 3'h3, 1'b0, 5'h00, 4'h0}, '{4'h0, 3'h4, 1'b1, 5'h10, 4'h7},
      '{4'h8, 3'h4, 1'b0, 5'h10, 4'h7}};
   ipfe_top i_ipfe_top (.clock_in(clk), .reset_in(rst), .enable_in(en), .nmi_in(pins[0]),
      .external_request_line_4_in(pins[1]), .external_request_line_5_in(pins[2]),
      .external_request_line_6_in(pins[3]), .external_request_line_7_in(pins[4]),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_q), .pending_out(pend), .nmi_pending_out(nmip),
      .service_acknowledge_out(ack), .serviced_id_bit_3_out(id[3]), .serviced_id_bit_2_out(id[2]),
      .serviced_id_bit_1_out(id[1]), .serviced_id_bit_0_out(id[0]));
   ipfe_src i_ipfe_src (.clock_in(clk), .set_in(set), .sel_in(sel), .level_in(lvl), .ack_in(ack),
      .id_in(id), .pins_out(pins), .acks_out(acks), .id_out(last_id));
   always #5 clk = ~clk;
   task automatic results;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         fails++;
      end
   endtask
   // One Avalon cycle; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wait_q !== 1'b0 && n < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      if (n >= 20)
      begin
         fails++;
         results();
      end
   endtask
   task automatic pin(input logic [2:0] s, input logic v);
      sel <= s;
      lvl <= v;
      set <= 1'b1;
      @(posedge clk);
      set <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic pchk(input logic [4:0] e);
      bus(1'b0, 4'h4, 32'h0);
      chk("pending reg", {27'h0, e}, q);
      chk("pending pins", {27'h0, e}, {27'h0, pend, nmip});
   endtask
   task automatic svc(input logic [3:0] e, input logic [7:0] k);
      nacks = nacks + k;
      bus(1'b1, 4'h8, 32'h10);
      repeat (2) @(posedge clk);
      chk("acks", {24'h0, nacks}, {24'h0, acks});
      chk("id", {28'h0, e}, {28'h0, last_id});
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("wait idle", 32'h1, {31'h0, wait_q});
      bus(1'b0, 4'h0, 32'h0);
      chk("polarity", {28'h0, IPFE_POL_RESET}, q);
      svc(4'h0, 8'h00);
      foreach (rows[i])
      begin
         bus(1'b1, 4'h0, {28'h0, rows[i].pol});
         pin(rows[i].sel, rows[i].lvl);
         pchk(rows[i].pend);
         if (rows[i].pend != 5'h00)
         begin
            svc(rows[i].id, 8'h01);
            pchk(5'h00);
         end
      end
      // Three at once are served by number
      bus(1'b1, 4'h0, 32'h0);
      pin(3'h4, 1'b1);
      pin(3'h0, 1'b1);
      pin(3'h2, 1'b1);
      pchk(5'h15);
      svc(4'h1, 8'h01);
      svc(4'h5, 8'h01);
      svc(4'h7, 8'h01);
      pchk(5'h00);
      // Enable low freezes everything, so a pulse on line 4 is never seen
      en <= 1'b0;
      pin(3'h1, 1'b0);
      pin(3'h1, 1'b1);
      chk("frozen", 32'h1, {26'h0, pend, nmip, wait_q});
      en <= 1'b1;
      pchk(5'h00);
      bus(1'b0, 4'hc, 32'h0);
      chk("unmapped", IPFE_UNMAPPED, q);
      pin(3'h0, 1'b0);
      pin(3'h0, 1'b1);
      rst <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("reset state", 32'h1, {21'h0, id, pend, nmip, ack, wait_q});
      chk("reset rdata", 32'h0, rdata);
      @(posedge clk);
      rst <= 1'b0;
      // Nonmaskable pin stays high through reset: a level, no request
      repeat (6) @(posedge clk);
      pchk(5'h00);
      results();
   end
endmodule
`default_nettype wire

// ==== testbench/ipfe_src.sv ====
// Model of the interrupt sources and of board logic watching acknowledge.
// Assumes bench commands arrive on the core clock.
`timescale 1ns/1ns
`default_nettype none
module ipfe_src (
   input  wire logic       clock_in,
   input  wire logic       set_in,
   input  wire logic [2:0] sel_in,
   input  wire logic       level_in,
   input  wire logic       ack_in,
   input  wire logic [3:0] id_in,
   output logic      [4:0] pins_out,
   output logic      [7:0] acks_out,
   output logic      [3:0] id_out
);
   logic [4:0] pins = 5'h00;
   logic [7:0] acks = 8'h00;
   logic [3:0] last = 4'h0;
   assign pins_out = pins;
   assign acks_out = acks;
   assign id_out   = last;
   // Pins hold their level; acknowledge counted per high cycle
   always @(posedge clock_in)
   begin
      if (set_in)
         pins[sel_in] <= level_in;
      if (ack_in === 1'b1)
      begin
         acks <= acks + 8'h01;
         last <= id_in;
      end
   end
endmodule
`default_nettype wire
